// ---- src/ssp_top.sv ----
// Synchronous serial master/slave port with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
module ssp_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial clock pin
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  // Controller-out data pin
  input  wire logic        peripheral_in_controller_out_pin_i,
  output logic             peripheral_in_controller_out_pin_o,
  output logic             peripheral_in_controller_out_pin_oe,
  // Controller-in data pin
  input  wire logic        peripheral_out_controller_in_pin_i,
  output logic             peripheral_out_controller_in_pin_o,
  output logic             peripheral_out_controller_in_pin_oe,
  // Interrupt requests and power state
  input  wire logic        low_power_entry,
  output logic             irq_level1,
  output logic             irq_level2
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  ssp_pkg::ssp_cfg_t   cfg_r;
  logic                mstr_r;
  logic                txen_r;
  logic                ien_r;
  logic                lvl_r;
  logic                done_r;
  logic                ovr_r;
  logic [7:0]          dat_r;
  logic [7:0]          buf_r;
  ssp_pkg::ssp_state_t state_r;
  ssp_pkg::ssp_state_t state_nxt;
  logic [2:0]          bitcnt_r;
  logic                sclk_r;
  logic                half_r;
  logic [7:0]          presc_r;
  logic                sync1_r;
  logic                sync2_r;
  logic                sync3_r;
  logic                outbit_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake state
  logic                aw_held_r;
  logic [5:0]          aw_addr_r;
  logic                w_held_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;

  // Address and data capture, either order; response after both
  // A taken channel waits for the response
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;

  // Write decode
  wire wr_lane0 = wr_fire && w_strb_r[0];
  wire wr_cfg   = wr_lane0 && (aw_addr_r == ssp_pkg::ADDR_CFG);
  wire wr_ctl   = wr_lane0 && (aw_addr_r == ssp_pkg::ADDR_CTL);
  wire wr_dat   = wr_lane0 && (aw_addr_r == ssp_pkg::ADDR_DAT);
  wire wr_pri   = wr_lane0 && (aw_addr_r == ssp_pkg::ADDR_PRI);
  wire wr_known = (aw_addr_r == ssp_pkg::ADDR_CFG) ||
                  (aw_addr_r == ssp_pkg::ADDR_CTL) ||
                  (aw_addr_r == ssp_pkg::ADDR_DAT) ||
                  (aw_addr_r == ssp_pkg::ADDR_PRI) ||
                  (aw_addr_r == ssp_pkg::ADDR_PWR) ||
                  (aw_addr_r == ssp_pkg::ADDR_BUF);

  // Read decode; a buffer read clears both flags
  wire rd_buf   = ar_take && (s_axi_araddr == ssp_pkg::ADDR_BUF);
  wire rd_known = (s_axi_araddr == ssp_pkg::ADDR_CFG) ||
                  (s_axi_araddr == ssp_pkg::ADDR_CTL) ||
                  (s_axi_araddr == ssp_pkg::ADDR_BUF) ||
                  (s_axi_araddr == ssp_pkg::ADDR_DAT) ||
                  (s_axi_araddr == ssp_pkg::ADDR_PRI) ||
                  (s_axi_araddr == ssp_pkg::ADDR_PWR);
  wire [7:0] ctl_view = {ovr_r, done_r, 3'h0, mstr_r, txen_r, ien_r};
  wire [7:0] rd_byte  =
    (s_axi_araddr == ssp_pkg::ADDR_CFG) ? cfg_r :
    (s_axi_araddr == ssp_pkg::ADDR_CTL) ? ctl_view :
    (s_axi_araddr == ssp_pkg::ADDR_BUF) ? buf_r :
    (s_axi_araddr == ssp_pkg::ADDR_DAT) ? dat_r :
    (s_axi_araddr == ssp_pkg::ADDR_PRI) ? {1'b0, lvl_r, 6'h00} : 8'h00;

  // Write channel holding registers and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 6'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssp_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  // Only a buffer read has a side effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ssp_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_known ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  wire low_power = low_power_entry ||
                   (wr_lane0 && (aw_addr_r == ssp_pkg::ADDR_PWR));

  // Software-held fields; reset gives slave, silent, falling latch, 1 bit
  // Software should change fields under soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r  <= ssp_pkg::CFG_RST;
      mstr_r <= 1'b0;
      txen_r <= 1'b0;
      ien_r  <= 1'b0;
      lvl_r  <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= w_data_r[7:0];
      end
      if (wr_ctl) begin
        mstr_r <= w_data_r[ssp_pkg::CTL_MSTR];
        txen_r <= w_data_r[ssp_pkg::CTL_TXEN];
        ien_r  <= w_data_r[ssp_pkg::CTL_IEN];
      end
      if (wr_pri) begin
        lvl_r <= w_data_r[ssp_pkg::PRI_LVL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and master clock timing
  wire [7:0] presc_mask = 8'((9'h001 << cfg_r.rate) - 9'h001);
  wire       half_tick  = ((presc_r & presc_mask) == presc_mask);

  // Free-running prescaler; each tap gives a half bit period
  // Never restarted, so the first half period of a
  // character may be short; later ones are exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave clock synchroniser and edge detection
  // Third flop only keeps the old level for the compare;
  // edges show two clocks late, so the far clock
  // must stay at or below an eighth of the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= serial_clock_pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Drive edge leaves idle level; sample edge returns to it
  // Flops reset low, the idle level after reset
  wire s_edge     = sync2_r != sync3_r;
  wire s_to_idle  = s_edge && (sync2_r == cfg_r.pol);
  wire s_from_idl = s_edge && (sync2_r != cfg_r.pol);

  ////////////////////////////////////////////////////////////////////////////
  // Shift sequencing
  wire run     = !cfg_r.srst;
  wire in_bit  = mstr_r ? peripheral_out_controller_in_pin_i
                        : peripheral_in_controller_out_pin_i;
  wire m_drive = mstr_r && (state_r == ssp_pkg::SSP_SHIFT) && half_tick &&
                 !half_r;
  wire m_samp  = mstr_r && (state_r == ssp_pkg::SSP_SHIFT) && half_tick &&
                 half_r;
  wire sl_samp = !mstr_r && run && s_to_idle;
  wire sl_drv  = !mstr_r && run && s_from_idl;
  wire samp    = m_samp || sl_samp;
  wire last    = bitcnt_r == cfg_r.len;
  wire char_end = samp && last;
  wire [7:0] shifted = {dat_r[6:0], in_bit};

  // Next state for the master sequencer
  // Soft reset or slave mode drops a character in flight
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ssp_pkg::SSP_IDLE: begin
        if (wr_dat && mstr_r && run) begin
          state_nxt = ssp_pkg::SSP_SHIFT;
        end
      end
      ssp_pkg::SSP_SHIFT: begin
        if (char_end) begin
          state_nxt = ssp_pkg::SSP_DONE;
        end
      end
      ssp_pkg::SSP_DONE: begin
        state_nxt = ssp_pkg::SSP_IDLE;
      end
      default: begin
        state_nxt = ssp_pkg::SSP_IDLE;
      end
    endcase
    if (!run || !mstr_r) begin
      state_nxt = ssp_pkg::SSP_IDLE;
    end
  end

  // Sequencer, bit counter and master clock level
  // A master-mode data write restarts the count, so writing during a
  // transfer corrupts that character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= ssp_pkg::SSP_IDLE;
      bitcnt_r <= 3'h0;
      half_r   <= 1'b0;
      sclk_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (!run || state_r != ssp_pkg::SSP_SHIFT) begin
        half_r <= 1'b0;
        sclk_r <= 1'b0;
      end else if (half_tick) begin
        half_r <= !half_r;
        sclk_r <= !sclk_r;
      end
      if (!run || (wr_dat && mstr_r) || char_end) begin
        bitcnt_r <= 3'h0;
      end else if (samp) begin
        bitcnt_r <= bitcnt_r + 3'h1;
      end
    end
  end

  // Output bit and receive sample; data register shifts on sample edge
  // First bit shows at the data write, before any edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dat_r    <= ssp_pkg::DAT_RST;
      outbit_r <= 1'b0;
    end else begin
      if (wr_dat) begin
        dat_r    <= w_data_r[7:0];
        outbit_r <= w_data_r[7];
      end else if (samp) begin
        dat_r <= shifted;
      end else if (m_drive || sl_drv) begin
        outbit_r <= dat_r[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flags
  // Low-power entry clears done only, not overrun
  wire srst_wr  = wr_cfg && w_data_r[ssp_pkg::CFG_SRST];
  wire clr_done = rd_buf || low_power || srst_wr || cfg_r.srst;
  wire clr_ovr  = rd_buf || srst_wr || cfg_r.srst;

  // Buffer takes full shift contents so older bits sit above the new ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r  <= ssp_pkg::BUF_RST;
      done_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      if (char_end) begin
        buf_r <= {dat_r[6:0], in_bit};
      end
      // A character ending in a clearing cycle still sets, unless soft reset is held
      if (char_end && !cfg_r.srst) begin
        done_r <= 1'b1;
        ovr_r  <= ovr_r || done_r;
      end else begin
        if (clr_done) begin
          done_r <= 1'b0;
        end
        if (clr_ovr) begin
          ovr_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request level select; enable masks only
  // Enable leaves the flag alone; unmasking re-raises it
  wire irq_req = done_r && ien_r;
  assign irq_level1 = irq_req && !lvl_r;
  assign irq_level2 = irq_req && lvl_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive via one carrier; polarity sets idle level
  ssp_pkg::ssp_pins_t pins;
  assign pins = {sclk_r ^ cfg_r.pol,
                 mstr_r,
                 outbit_r,
                 mstr_r && txen_r,
                 !mstr_r && txen_r};
  assign serial_clock_pin_o  = pins.clk_o;
  assign serial_clock_pin_oe = pins.clk_oe;
  assign peripheral_in_controller_out_pin_o   = pins.data_o;
  assign peripheral_in_controller_out_pin_oe  = pins.picd_oe;
  assign peripheral_out_controller_in_pin_o   = pins.data_o;
  assign peripheral_out_controller_in_pin_oe  = pins.poci_oe;

endmodule // ssp_top

// ---- shared/ssp_pkg.sv ----
// Constants, register map and carrier types of the synchronous serial port
//
// Operation
// - Master drives the shift clock, outputs on one edge, samples on other.
// - Master sends on controller-out pin, samples controller-in pin.
// - Master write of shift data starts a transfer, MSB first, shifting in.
// - After the last bit the shift register is copied into receive buffer.
// - Receive data shifts in MSB first, lands right-justified in buffer.
// - Character done sets done flag, loads buffer, raises enabled request.
// - Slave sends on controller-in pin, receives on controller-out pin.
// - Slave waits for external clock edges, shifting data out and in.
// - Transmit disabled puts serial data output in high impedance.
// - Three-bit length field; bit counter detects complete character.
// - Buffer upper bits keep earlier shifted bits, never cleared.
// - Done flag clears on buffer read, low power, soft reset, reset.
// - Enable only masks request; flag still set reasserts request.
// - Priority select zero gives level 1 request, one gives level 2.
// - Character done before buffer read overwrites buffer and sets overrun.
// - Edge polarity bit selects rising or falling active edge.
// - Master bit rate is system clock over two times two to the b.
// - Reset gives slave, no transmit, falling latch, 1-bit, no irq, 00h.
// - Polarity 0 idles low, drives rising; 1 idles high, drives falling.
// - Soft reset clears flags, keeps config, idles clock, drops pending char.
// - Overrun clears on buffer read, soft reset or system reset.
// - Length field value plus one gives character length.
package ssp_pkg;

  // Register byte addresses (one aligned word each)
  localparam logic [5:0] ADDR_CFG  = 6'h00;
  localparam logic [5:0] ADDR_CTL  = 6'h04;
  localparam logic [5:0] ADDR_BUF  = 6'h1c;
  localparam logic [5:0] ADDR_DAT  = 6'h24;
  localparam logic [5:0] ADDR_PRI  = 6'h3c;
  localparam logic [5:0] ADDR_PWR  = 6'h30;

  // Configuration register fields
  localparam int CFG_SRST  = 7;
  localparam int CFG_POL   = 6;
  localparam int CFG_RATE  = 3;
  localparam int CFG_LEN   = 0;
  // Control register fields
  localparam int CTL_OVR   = 7;
  localparam int CTL_DONE  = 6;
  localparam int CTL_MSTR  = 2;
  localparam int CTL_TXEN  = 1;
  localparam int CTL_IEN   = 0;
  // Priority register field
  localparam int PRI_LVL   = 6;

  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] CTL_RST = 3'h0;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int SYS_CLK_HZ = 40000000;
  localparam int PRESC_W    = 8;

  // Master sequencer states
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_SHIFT = 2'b01,
    SSP_DONE  = 2'b10
  } ssp_state_t;

  // Configuration carrier
  typedef struct packed {
    logic       srst;
    logic       pol;
    logic [2:0] rate;
    logic [2:0] len;
  } ssp_cfg_t;

  // Serial pin bundle driven by the port
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic data_o;
    logic picd_oe;
    logic poci_oe;
  } ssp_pins_t;

endpackage : ssp_pkg

// ---- test/ssp_checker.sv ----
// Port-level assertions for the synchronous serial port
module ssp_checker (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic [5:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Pin enables, power entry and requests
  input wire logic       serial_clock_pin_oe,
  input wire logic       peripheral_in_controller_out_pin_oe,
  input wire logic       peripheral_out_controller_in_pin_oe,
  input wire logic       low_power_entry,
  input wire logic       irq_level1,
  input wire logic       irq_level2
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic irq;
  // Either request level
  assign irq = irq_level1 | irq_level2;

  // Bus steps and the request drop that follows a clearing event
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_buf_rd;
    s_rd ##0 (s_axi_araddr == ssp_pkg::ADDR_BUF);
  endsequence
  sequence s_irq_gone;
    ##[1:2] !irq;
  endsequence

  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq &&
    !serial_clock_pin_oe && !peripheral_in_controller_out_pin_oe &&
    !peripheral_out_controller_in_pin_oe)
    else $error("outputs active right after reset");
  chk_master_clock: assert property (peripheral_in_controller_out_pin_oe
    |-> serial_clock_pin_oe)
    else $error("master data driven without clock drive");
  chk_slave_input: assert property (peripheral_out_controller_in_pin_oe
    |-> !serial_clock_pin_oe)
    else $error("slave data driven while clock is driven");
  chk_irq_level: assert property (!(irq_level1 && irq_level2))
    else $error("both request levels active");
  chk_read_clear: assert property (s_buf_rd |-> s_irq_gone)
    else $error("request stays after buffer read");
  chk_sleep_clear: assert property (low_power_entry |-> s_irq_gone)
    else $error("request stays after low power entry");
  chk_write_resp: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_resp: assert property (s_rd |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read response late or address accepted");
endmodule // ssp_checker

bind ssp_top ssp_checker u_chk (.*);

// ---- test/ssp_far_end.sv ----
// Behavioural far end of the serial link: slave or external master
module ssp_far_end (
  // Resolved serial lines
  input wire logic sck,
  input wire logic pico,
  input wire logic poci,
  // Idle level of the shift clock
  input wire logic pol,
  // Levels this side drives
  output logic     p_sck,
  output logic     p_pico,
  output logic     p_poci
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx;
  logic [7:0] rx;
  int         nsmp;
  logic       mst;
  realtime    t_lv;
  realtime    t_rt;

  // Quiet start
  initial begin
    {p_sck, p_pico, p_poci, mst, tx, rx} = '0;
    nsmp = 0;
  end

  // Arm a character to send as slave; its MSB shows at once
  task automatic load(input logic [7:0] d);
    tx = d;
    rx = 8'h00;
    nsmp = 0;
    p_poci = d[7];
  endtask

  // Slave side: next bit on leaving idle, capture on the return
  always @(sck) begin
    if (!mst && sck !== pol) begin
      t_lv = $realtime;
      if (nsmp > 0 && nsmp < 8) p_poci = tx[7 - nsmp];
    end else if (!mst) begin
      t_rt = $realtime;
      rx = {rx[6:0], pico};
      nsmp++;
    end
  end

  // External master: half period of four system clocks, off-phase
  task automatic run_master(input int n, input logic [7:0] d);
    mst = 1'b1;
    rx = 8'h00;
    p_sck = pol;
    p_pico = d[7];
    #10ns;
    for (int i = 0; i < n; i++) begin
      #100ns;
      p_sck = ~pol;
      if (i > 0) p_pico = d[7 - i];
      #100ns;
      p_sck = pol;
      rx = {rx[6:0], poci};
    end
    #100ns;
    p_pico = ~p_pico;
    mst = 1'b0;
  endtask
endmodule // ssp_far_end

// ---- test/ssp_top_bench.sv ----
// Self-checking bench for the synchronous serial port
module ssp_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////
  // Design ports, named as on the design
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, low_power_entry;
  logic        irq_level1, irq_level2, serial_clock_pin_i;
  logic        serial_clock_pin_o, serial_clock_pin_oe;
  logic        peripheral_in_controller_out_pin_i;
  logic        peripheral_in_controller_out_pin_o;
  logic        peripheral_in_controller_out_pin_oe;
  logic        peripheral_out_controller_in_pin_i;
  logic        peripheral_out_controller_in_pin_o;
  logic        peripheral_out_controller_in_pin_oe;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // Far end levels and bench state
  logic        p_sck, p_pico, p_poci, pol;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          mismatches, n_compared, cyc;
  logic [7:0]  t_cfg [3] = '{8'h0f, 8'h44, 8'h38};
  logic [7:0]  t_dat [3] = '{8'ha5, 8'hd0, 8'h80};
  logic [7:0]  t_far [3] = '{8'h3c, 8'h5a, 8'hff};

  // Wire levels from whoever enables its driver
  assign serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o
                                                  : p_sck;
  assign peripheral_in_controller_out_pin_i = peripheral_in_controller_out_pin_oe
    ? peripheral_in_controller_out_pin_o : p_pico;
  assign peripheral_out_controller_in_pin_i = peripheral_out_controller_in_pin_oe
    ? peripheral_out_controller_in_pin_o : p_poci;

  ssp_top i_dut (.*);
  ssp_far_end u_far (.sck(serial_clock_pin_i),
    .pico(peripheral_in_controller_out_pin_i),
    .poci(peripheral_out_controller_in_pin_i), .pol(pol),
    .p_sck(p_sck), .p_pico(p_pico), .p_poci(p_poci));

  ////////////////////////////////////////////////////////////////////////
  // System clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5ns aclk = ~aclk;
  end

  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Bus write; address and data offered together
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] er = ssp_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
  endtask

  // Bus read into rv and rr
  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read and compare one register word
  task automatic rc(input logic [5:0] a, input logic [7:0] e,
                    input logic [1:0] er = ssp_pkg::RESP_OKAY);
    rd(a);
    chk("read data", {24'h0, e}, rv);
    chk("read response", {30'h0, er}, {30'h0, rr});
  endtask

  // Poll the control word until one flag shows
  task automatic wait_bit(input int b);
    do rd(ssp_pkg::ADDR_CTL);
    while (rv[b] !== 1'b1);
  endtask

  // One master character; no data write until it has finished
  task automatic xfer(input logic [7:0] d, p, input int b);
    u_far.load(p);
    wr(ssp_pkg::ADDR_DAT, d);
    wait_bit(b);
  endtask

  // Configure under soft reset, send, then check every outcome
  task automatic master_case(input logic [7:0] c, d, p, input logic pri);
    int          n;
    logic [15:0] sh;
    n = int'(c[2:0]) + 1;
    sh = {8'h00, d} << n;
    pol = c[6];
    wr(ssp_pkg::ADDR_CFG, c | 8'h80);
    wr(ssp_pkg::ADDR_CTL, 8'h07);
    wr(ssp_pkg::ADDR_PRI, {1'b0, pri, 6'h00});
    wr(ssp_pkg::ADDR_CFG, c);
    chk("idle clock", {31'h0, pol}, {31'h0, serial_clock_pin_i});
    xfer(d, p, ssp_pkg::CTL_DONE);
    chk("level one", {31'h0, !pri}, {31'h0, irq_level1});
    chk("level two", {31'h0, pri}, {31'h0, irq_level2});
    chk("far rx", {24'h0, d >> (8 - n)}, {24'h0, u_far.rx});
    chk("half period", 32'(25 * (1 << c[5:3])),
        int'(u_far.t_rt - u_far.t_lv));
    wr(ssp_pkg::ADDR_CTL, 8'h06);
    chk("masked", 32'h0, {31'h0, irq_level1 | irq_level2});
    wr(ssp_pkg::ADDR_CTL, 8'h07);
    chk("unmasked", 32'h1, {31'h0, irq_level1 | irq_level2});
    rc(ssp_pkg::ADDR_BUF, sh[7:0] | (p >> (8 - n)));
    rc(ssp_pkg::ADDR_CTL, 8'h07);
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, low_power_entry, aresetn, pol} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {mismatches, n_compared, cyc} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(ssp_pkg::ADDR_CFG, ssp_pkg::CFG_RST);
    rc(ssp_pkg::ADDR_CTL, {5'h0, ssp_pkg::CTL_RST});
    rc(ssp_pkg::ADDR_DAT, ssp_pkg::DAT_RST);
    rc(ssp_pkg::ADDR_BUF, ssp_pkg::BUF_RST);
    rc(6'h08, 8'h00, ssp_pkg::RESP_SLVERR);
    wr(6'h08, 8'hff, ssp_pkg::RESP_SLVERR);
    // Short data is written left-justified
    for (int i = 0; i < 3; i++)
      master_case(t_cfg[i], t_dat[i], t_far[i], i[0]);
    // Overrun, then low-power entry and buffer read
    pol = 1'b0;
    wr(ssp_pkg::ADDR_CFG, 8'h87);
    wr(ssp_pkg::ADDR_CFG, 8'h07);
    xfer(8'h11, 8'h22, ssp_pkg::CTL_DONE);
    xfer(8'h33, 8'h44, ssp_pkg::CTL_OVR);
    rc(ssp_pkg::ADDR_CTL, 8'hc7);
    low_power_entry <= 1'b1;
    @(posedge aclk);
    low_power_entry <= 1'b0;
    @(posedge aclk);
    rc(ssp_pkg::ADDR_CTL, 8'h87);
    rc(ssp_pkg::ADDR_BUF, 8'h44);
    rc(ssp_pkg::ADDR_CTL, 8'h07);
    // Soft reset clears flags, keeps setup, drops a pending character
    xfer(8'h55, 8'h66, ssp_pkg::CTL_DONE);
    wr(ssp_pkg::ADDR_CFG, 8'h87);
    rc(ssp_pkg::ADDR_CTL, 8'h07);
    rc(ssp_pkg::ADDR_CFG, 8'h87);
    wr(ssp_pkg::ADDR_DAT, 8'hf0);
    wr(ssp_pkg::ADDR_CFG, 8'h07);
    repeat (40) @(posedge aclk);
    rc(ssp_pkg::ADDR_CTL, 8'h07);
    // Slave character clocked by the far end
    wr(ssp_pkg::ADDR_CFG, 8'h87);
    wr(ssp_pkg::ADDR_CTL, 8'h02);
    wr(ssp_pkg::ADDR_CFG, 8'h07);
    wr(ssp_pkg::ADDR_DAT, 8'h96);
    u_far.run_master(8, 8'h4b);
    @(posedge aclk);
    wait_bit(ssp_pkg::CTL_DONE);
    wr(ssp_pkg::ADDR_PWR, 8'h00);
    rc(ssp_pkg::ADDR_CTL, 8'h02);
    rc(ssp_pkg::ADDR_BUF, 8'h4b);
    chk("far rx", 32'h96, {24'h0, u_far.rx});
    wr(ssp_pkg::ADDR_CTL, 8'h04);
    chk("data enable", 32'h0, {31'h0, peripheral_in_controller_out_pin_oe |
        peripheral_out_controller_in_pin_oe});
    end_sim;
  end
endmodule // ssp_top_bench
